// ===== rtl/bpm_pin_mux.sv
// Purpose: Pin mux and direction control of chip-select, strobe and bus-control ports.
// Assumes: Pin inputs synchronous to clk; read data valid one cycle after rd.
// Notes: Pin drive and controller inputs are registered, adding one cycle.
`timescale 1ns/1ps
module bpm_pin_mux
  import bpm_pkg::*;
#(
  parameter int ADDR_W_P = bpm_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire bpm_pkg::bpm_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  // Bus controller side
  input wire bpm_pkg::bpm_ctl_out_type ctl_out,
  output bpm_pkg::bpm_ctl_in_type ctl_in,
  // Chip-select port pins
  input wire logic [7:0] cs_pin_in,
  output bpm_pkg::bpm_pin_type cs_pin,
  // Strobe port pins
  input wire logic [7:0] stb_pin_in,
  output bpm_pkg::bpm_pin_type stb_pin,
  // Bus-control port pins
  input wire logic [7:0] ctl_pin_in,
  output bpm_pkg::bpm_pin_type ctl_pin
);
  import bpm_pkg::*;

  if (ADDR_W_P != ADDR_W) begin : g_bad_addr
    $error("Address width must match the register map");
  end

  typedef struct packed {
    logic [7:0] rdata;
    bpm_ctl_in_type ctl_in;
  } bpm_main_state_type;

  bpm_main_state_type st_ff;
  bpm_main_state_type nxt_st;

  logic [7:0] regs [NUM_REGS];
  logic [7:0] cs_alt;
  logic [7:0] stb_alt;
  logic [7:0] ctl_alt;
  logic [7:0] cs_drv;
  logic [7:0] stb_drv;
  logic [7:0] ctl_drv;
  logic [7:0] cs_view;
  logic [7:0] stb_view;
  logic [7:0] ctl_view;
  logic [7:0] rd_mux;
  logic [7:0] cs_pin_out;
  logic [7:0] cs_pin_oe;
  logic [7:0] stb_pin_out;
  logic [7:0] stb_pin_oe;
  logic [7:0] ctl_pin_out;
  logic [7:0] ctl_pin_oe;

  // Register file
  for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
    bpm_reg8 #(
      .RESET(REG_RST[r]),
      .MASK(REG_MSK[r])
    ) u_reg (
      .clk(clk),
      .rst_b(rst_b),
      .wr(reg_req.wr && (reg_req.addr == REG_OFF[r])),
      .wdata(reg_req.wdata),
      .wmask(reg_req.wmask),
      .q(regs[r])
    );
  end

  // Alternate output selection, chip-select port
  always_comb begin
    cs_alt = ctl_out.chip_select_n;
    if (regs[IDX_CS_ALT][CS_IO_READ_BIT]) begin
      cs_alt[CS_IO_READ_BIT] = ctl_out.io_read_strobe;
    end
    if (regs[IDX_CS_ALT][CS_IO_STORE_BIT]) begin
      cs_alt[CS_IO_STORE_BIT] = ctl_out.io_store_strobe;
    end
  end

  // Alternate output selection, strobe port
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ctl_out.sdram_access) begin
        stb_alt[i] = ctl_out.lane_data_mask[i];
      end else if (regs[IDX_STB_LANE][i]) begin
        stb_alt[i] = ctl_out.lane_byte_enable[i];
      end else begin
        stb_alt[i] = ctl_out.lane_store_strobe[i];
      end
    end
    stb_alt[STB_RD_BIT] = ctl_out.read_strobe;
    stb_alt[STB_WE_BIT] = ctl_out.sdram_access ? ctl_out.sdram_store_enable
                                               : ctl_out.store_strobe;
    stb_alt[STB_ABSENT_BIT] = regs[IDX_STB_DATA][STB_ABSENT_BIT];
    stb_alt[STB_BCY_BIT] = ctl_out.bus_cycle_start_status;
  end

  // Alternate output selection, bus-control port; input functions keep the latch
  always_comb begin
    ctl_alt = regs[IDX_CTL_DATA];
    ctl_alt[CTL_HOLD_ACK_BIT] = ctl_out.hold_acknowledge;
    ctl_alt[CTL_REFRESH_BIT] = ctl_out.refresh_request;
  end

  // Pin drivers; port-mode pins ignore the alt and lane selects
  for (genvar p = 0; p < 8; p++) begin : g_pin
    bpm_pin_slice u_cs (
      .clk(clk),
      .rst_b(rst_b),
      .dir_in(regs[IDX_CS_DIR][p]),
      .func_en(regs[IDX_CS_FUNC][p]),
      .latch(regs[IDX_CS_DATA][p]),
      .alt_val(cs_alt[p]),
      .pin_out(cs_pin_out[p]),
      .pin_oe(cs_pin_oe[p]),
      .drive_val(cs_drv[p])
    );
    bpm_pin_slice u_stb (
      .clk(clk),
      .rst_b(rst_b),
      .dir_in(regs[IDX_STB_DIR][p]),
      .func_en(regs[IDX_STB_FUNC][p]),
      .latch(regs[IDX_STB_DATA][p]),
      .alt_val(stb_alt[p]),
      .pin_out(stb_pin_out[p]),
      .pin_oe(stb_pin_oe[p]),
      .drive_val(stb_drv[p])
    );
    bpm_pin_slice u_ctl (
      .clk(clk),
      .rst_b(rst_b),
      .dir_in(regs[IDX_CTL_DIR][p]),
      .func_en(regs[IDX_CTL_FUNC][p]),
      .latch(regs[IDX_CTL_DATA][p]),
      .alt_val(ctl_alt[p]),
      .pin_out(ctl_pin_out[p]),
      .pin_oe(ctl_pin_oe[p]),
      .drive_val(ctl_drv[p])
    );
  end

  // Data register view: pin level for inputs, driven value for outputs
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cs_view[i] = regs[IDX_CS_DIR][i] ? cs_pin_in[i] : cs_drv[i];
      stb_view[i] = regs[IDX_STB_DIR][i] ? stb_pin_in[i] : stb_drv[i];
      ctl_view[i] = regs[IDX_CTL_DIR][i] ? ctl_pin_in[i] : ctl_drv[i];
    end
    stb_view = stb_view & MSK_STB;
    ctl_view = ctl_view & MSK_CTL;
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    rd_mux = 8'h00;
    for (int r = 0; r < NUM_REGS; r++) begin
      if (reg_req.addr == REG_OFF[r]) begin
        rd_mux = regs[r];
      end
    end
    if (reg_req.addr == OFF_CS_DATA) begin
      rd_mux = cs_view;
    end
    if (reg_req.addr == OFF_STB_DATA) begin
      rd_mux = stb_view;
    end
    if (reg_req.addr == OFF_CTL_DATA) begin
      rd_mux = ctl_view;
    end
  end

  // Next state: read data and controller inputs
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = reg_req.rd ? rd_mux : 8'h00;
    // Port-mode pins feed the controller its idle level
    nxt_st.ctl_in.wait_b = regs[IDX_CTL_FUNC][CTL_WAIT_BIT] ?
                           ctl_pin_in[CTL_WAIT_BIT] : 1'b1;
    nxt_st.ctl_in.hold_request_b = regs[IDX_CTL_FUNC][CTL_HOLD_REQ_BIT] ?
                                   ctl_pin_in[CTL_HOLD_REQ_BIT] : 1'b1;
    nxt_st.ctl_in.self_refresh_request_b = regs[IDX_CTL_FUNC][CTL_SELF_BIT] ?
                                           ctl_pin_in[CTL_SELF_BIT] : 1'b1;
    nxt_st.ctl_in.adc_external_trigger = regs[IDX_CTL_FUNC][CTL_SELF_BIT] ?
                                         ctl_pin_in[CTL_SELF_BIT] : 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{rdata: 8'h00, ctl_in: '{1'b1, 1'b1, 1'b1, 1'b1}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs; absent strobe pin 6 and bus-control pins 6, 7 never drive
  assign reg_rdata = st_ff.rdata;
  assign ctl_in = st_ff.ctl_in;
  assign cs_pin.out = cs_pin_out;
  assign cs_pin.oe = cs_pin_oe;
  assign stb_pin.out = stb_pin_out & MSK_STB;
  assign stb_pin.oe = stb_pin_oe & MSK_STB;
  assign ctl_pin.out = ctl_pin_out & MSK_CTL;
  assign ctl_pin.oe = ctl_pin_oe & MSK_CTL;
endmodule

// ===== inc/bpm_pkg.sv
// Purpose: Constants, register map and carrier types of the bus-control pin mux.
// Assumes: Byte-wide registers on a plain strobe port, one clock domain.
// Notes:
package bpm_pkg;
  localparam int ADDR_W = 32;
  localparam int NUM_REGS = 11;

  localparam logic [31:0] OFF_CS_DIR = 32'hFFFFF028;
  localparam logic [31:0] OFF_CS_FUNC = 32'hFFFFF048;
  localparam logic [31:0] OFF_CS_ALT = 32'hFFFFF049;
  localparam logic [31:0] OFF_STB_DIR = 32'hFFFFF02A;
  localparam logic [31:0] OFF_STB_FUNC = 32'h0FFFF04A;
  localparam logic [31:0] OFF_STB_LANE = 32'h0FFFF04B;
  localparam logic [31:0] OFF_CTL_DIR = 32'hFFFFF02C;
  localparam logic [31:0] OFF_CTL_FUNC = 32'hFFFFF04C;
  localparam logic [31:0] OFF_CS_DATA = 32'hFFFFF008;
  localparam logic [31:0] OFF_STB_DATA = 32'hFFFFF00A;
  localparam logic [31:0] OFF_CTL_DATA = 32'hFFFFF00C;

  localparam logic [7:0] RST_CS_DIR = 8'hFF;
  localparam logic [7:0] RST_CS_FUNC = 8'hFF;
  localparam logic [7:0] RST_CS_ALT = 8'h00;
  localparam logic [7:0] RST_STB_DIR = 8'hFF;
  localparam logic [7:0] RST_STB_FUNC = 8'hBF;
  localparam logic [7:0] RST_STB_LANE = 8'h00;
  localparam logic [7:0] RST_CTL_DIR = 8'hFF;
  localparam logic [7:0] RST_CTL_FUNC = 8'h3D;
  localparam logic [7:0] RST_DATA = 8'h00;

  // Writable bits per register
  localparam logic [7:0] MSK_ALL = 8'hFF;
  localparam logic [7:0] MSK_CS_ALT = 8'h24;
  localparam logic [7:0] MSK_STB = 8'hBF;
  localparam logic [7:0] MSK_STB_LANE = 8'h0F;
  localparam logic [7:0] MSK_CTL = 8'h3F;
  localparam logic [7:0] MSK_CTL_FUNC = 8'h3D;

  localparam int IDX_CS_DIR = 0;
  localparam int IDX_CS_FUNC = 1;
  localparam int IDX_CS_ALT = 2;
  localparam int IDX_STB_DIR = 3;
  localparam int IDX_STB_FUNC = 4;
  localparam int IDX_STB_LANE = 5;
  localparam int IDX_CTL_DIR = 6;
  localparam int IDX_CTL_FUNC = 7;
  localparam int IDX_CS_DATA = 8;
  localparam int IDX_STB_DATA = 9;
  localparam int IDX_CTL_DATA = 10;

  localparam logic [31:0] REG_OFF [NUM_REGS] = '{OFF_CS_DIR, OFF_CS_FUNC, OFF_CS_ALT,
    OFF_STB_DIR, OFF_STB_FUNC, OFF_STB_LANE, OFF_CTL_DIR, OFF_CTL_FUNC,
    OFF_CS_DATA, OFF_STB_DATA, OFF_CTL_DATA};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_CS_DIR, RST_CS_FUNC, RST_CS_ALT,
    RST_STB_DIR, RST_STB_FUNC, RST_STB_LANE, RST_CTL_DIR, RST_CTL_FUNC,
    RST_DATA, RST_DATA, RST_DATA};
  localparam logic [7:0] REG_MSK [NUM_REGS] = '{MSK_ALL, MSK_ALL, MSK_CS_ALT,
    MSK_STB, MSK_STB, MSK_STB_LANE, MSK_CTL, MSK_CTL_FUNC,
    MSK_ALL, MSK_STB, MSK_CTL};

  localparam int CS_IO_READ_BIT = 5;
  localparam int CS_IO_STORE_BIT = 2;
  localparam int STB_RD_BIT = 4;
  localparam int STB_WE_BIT = 5;
  localparam int STB_ABSENT_BIT = 6;
  localparam int STB_BCY_BIT = 7;
  localparam int CTL_WAIT_BIT = 0;
  localparam int CTL_HOLD_ACK_BIT = 2;
  localparam int CTL_HOLD_REQ_BIT = 3;
  localparam int CTL_REFRESH_BIT = 4;
  localparam int CTL_SELF_BIT = 5;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic wr;
    logic rd;
  } bpm_reg_req_type;

  typedef struct packed {
    logic [7:0] chip_select_n;
    logic io_read_strobe;
    logic io_store_strobe;
    logic sdram_access;
    logic [3:0] lane_store_strobe;
    logic [3:0] lane_byte_enable;
    logic [3:0] lane_data_mask;
    logic read_strobe;
    logic store_strobe;
    logic sdram_store_enable;
    logic bus_cycle_start_status;
    logic hold_acknowledge;
    logic refresh_request;
  } bpm_ctl_out_type;

  typedef struct packed {
    logic wait_b;
    logic hold_request_b;
    logic self_refresh_request_b;
    logic adc_external_trigger;
  } bpm_ctl_in_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } bpm_pin_type;
endpackage

// ===== rtl/bpm_reg8.sv
// Purpose: One byte-wide control register with per-bit write mask.
// Assumes: Bits outside MASK never change and hold their reset value.
// Notes: A single-bit access is a write with one mask bit set.
`timescale 1ns/1ps
module bpm_reg8 #(
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Write port
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wmask,
  // Contents
  output logic [7:0] q
);
  typedef struct packed {
    logic [7:0] val;
  } bpm_reg8_state_type;

  bpm_reg8_state_type st_ff;
  bpm_reg8_state_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr) begin
      nxt_st.val = (st_ff.val & ~(wmask & MASK)) | (wdata & wmask & MASK);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{val: RESET};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.val;
endmodule

// ===== rtl/bpm_pin_slice.sv
// Purpose: Registered driver of one multiplexed pin.
// Assumes: Direction and function bits come from control registers.
// Notes: Output enable follows direction alone, in port and function mode.
`timescale 1ns/1ps
module bpm_pin_slice (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control
  input wire logic dir_in,
  input wire logic func_en,
  input wire logic latch,
  input wire logic alt_val,
  // Pin drive
  output logic pin_out,
  output logic pin_oe,
  // Value seen by the pin driver
  output logic drive_val
);
  typedef struct packed {
    logic out;
    logic oe;
  } bpm_pin_state_type;

  bpm_pin_state_type st_ff;
  bpm_pin_state_type nxt_st;

  always_comb begin
    drive_val = func_en ? alt_val : latch;
    nxt_st.out = drive_val;
    nxt_st.oe = ~dir_in;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{out: 1'b0, oe: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.out;
  assign pin_oe = st_ff.oe;
endmodule

// ===== verif/bpm_pin_mux_props.sv
// Purpose: Port-level assertions for the bus-control pin mux.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Keeps a shadow of the registers built from observed writes.
`timescale 1ns/1ps
module bpm_pin_mux_props
  import bpm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire bpm_pkg::bpm_reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  // Controller side
  input wire bpm_pkg::bpm_ctl_out_type ctl_out,
  input wire bpm_pkg::bpm_ctl_in_type ctl_in,
  // Pins
  input wire logic [7:0] cs_pin_in,
  input wire bpm_pkg::bpm_pin_type cs_pin,
  input wire logic [7:0] stb_pin_in,
  input wire bpm_pkg::bpm_pin_type stb_pin,
  input wire logic [7:0] ctl_pin_in,
  input wire bpm_pkg::bpm_pin_type ctl_pin
);
  logic [7:0] sh_ff [NUM_REGS];
  logic [7:0] nxt_sh [NUM_REGS];
  logic [7:0] cs_sel, st_sel, fn, cs_exp, st_exp, ct_exp, rd_exp;
  bpm_ctl_in_type ci_exp;
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      fn = reg_req.wmask & REG_MSK[i];
      nxt_sh[i] = sh_ff[i];
      if (reg_req.wr && reg_req.addr == REG_OFF[i])
        nxt_sh[i] = (sh_ff[i] & ~fn) | (reg_req.wdata & fn);
    end
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) sh_ff <= REG_RST;
    else sh_ff <= nxt_sh;
  always_comb begin
    cs_sel = ctl_out.chip_select_n;
    if (sh_ff[IDX_CS_ALT][5]) cs_sel[5] = ctl_out.io_read_strobe;
    if (sh_ff[IDX_CS_ALT][2]) cs_sel[2] = ctl_out.io_store_strobe;
    for (int i = 0; i < 4; i++)
      st_sel[i] = ctl_out.sdram_access ? ctl_out.lane_data_mask[i] : sh_ff[IDX_STB_LANE][i] ?
        ctl_out.lane_byte_enable[i] : ctl_out.lane_store_strobe[i];
    st_sel[7:4] = {ctl_out.bus_cycle_start_status, 1'b0, ctl_out.sdram_access ?
      ctl_out.sdram_store_enable : ctl_out.store_strobe, ctl_out.read_strobe};
    cs_exp = (cs_sel & sh_ff[IDX_CS_FUNC]) | (sh_ff[IDX_CS_DATA] & ~sh_ff[IDX_CS_FUNC]);
    st_exp = (st_sel & sh_ff[IDX_STB_FUNC]) | (sh_ff[IDX_STB_DATA] & ~sh_ff[IDX_STB_FUNC]);
    ct_exp = sh_ff[IDX_CTL_DATA];
    if (sh_ff[IDX_CTL_FUNC][2]) ct_exp[2] = ctl_out.hold_acknowledge;
    if (sh_ff[IDX_CTL_FUNC][4]) ct_exp[4] = ctl_out.refresh_request;
    ci_exp.wait_b = !sh_ff[IDX_CTL_FUNC][0] | ctl_pin_in[0];
    ci_exp.hold_request_b = !sh_ff[IDX_CTL_FUNC][3] | ctl_pin_in[3];
    ci_exp.self_refresh_request_b = !sh_ff[IDX_CTL_FUNC][5] | ctl_pin_in[5];
    ci_exp.adc_external_trigger = !sh_ff[IDX_CTL_FUNC][5] | ctl_pin_in[5];
    rd_exp = 8'h00;
    for (int i = 0; i < NUM_REGS; i++)
      if (reg_req.addr == REG_OFF[i]) rd_exp = sh_ff[i];
    if (reg_req.addr == OFF_CS_DATA)
      rd_exp = (cs_pin_in & sh_ff[IDX_CS_DIR]) | (cs_exp & ~sh_ff[IDX_CS_DIR]);
    if (reg_req.addr == OFF_STB_DATA)
      rd_exp = ((stb_pin_in & sh_ff[IDX_STB_DIR]) | (st_exp & ~sh_ff[IDX_STB_DIR])) & MSK_STB;
    if (reg_req.addr == OFF_CTL_DATA)
      rd_exp = ((ctl_pin_in & sh_ff[IDX_CTL_DIR]) | (ct_exp & ~sh_ff[IDX_CTL_DIR])) & MSK_CTL;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RD_IDLE: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RD_DATA: assert property ($past(reg_req.rd) |-> reg_rdata == $past(rd_exp))
    else $error("read data wrong");
  AST_DIR_WR: assert property (reg_req.wr && reg_req.addr == OFF_CS_DIR &&
    reg_req.wmask == 8'hFF |-> ##2 cs_pin.oe == ~$past(reg_req.wdata, 2))
    else $error("cs direction write not seen");
  AST_CS_OE: assert property (cs_pin.oe == ~$past(sh_ff[IDX_CS_DIR]))
    else $error("cs enable wrong");
  AST_ST_OE: assert property (stb_pin.oe == (~$past(sh_ff[IDX_STB_DIR]) & MSK_STB))
    else $error("strobe enable wrong");
  AST_CT_OE: assert property (ctl_pin.oe == (~$past(sh_ff[IDX_CTL_DIR]) & MSK_CTL))
    else $error("bus control enable wrong");
  AST_CS_OUT: assert property ((cs_pin.out & cs_pin.oe) == ($past(cs_exp) & cs_pin.oe))
    else $error("cs pin value wrong");
  AST_ST_OUT: assert property ((stb_pin.out & stb_pin.oe) == ($past(st_exp) & stb_pin.oe))
    else $error("strobe pin value wrong");
  AST_CT_OUT: assert property ((ctl_pin.out & ctl_pin.oe) == ($past(ct_exp) & ctl_pin.oe))
    else $error("bus control pin value wrong");
  AST_CT_IN: assert property ($past(rst_b) |-> ctl_in == $past(ci_exp))
    else $error("controller input wrong");
  cover property (reg_req.wr && reg_req.addr == OFF_CS_ALT);
  cover property ($past(reg_req.rd) && $past(reg_req.addr) == OFF_CS_DATA);
  cover property ($fell(ctl_in.wait_b));
endmodule
bind bpm_pin_mux bpm_pin_mux_props u_props (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .ctl_out(ctl_out), .ctl_in(ctl_in), .cs_pin_in(cs_pin_in),
  .cs_pin(cs_pin), .stb_pin_in(stb_pin_in), .stb_pin(stb_pin), .ctl_pin_in(ctl_pin_in),
  .ctl_pin(ctl_pin));

// ===== verif/bpm_ext_model.sv
// Purpose: External memory and I/O devices on the pins.
// Assumes: Undriven lines float to a pattern set by the bench, except bus-control lines 0 (wait) and 3 (hold request).
// Notes: A slow device pulls wait low after chip select 0 drops.
`timescale 1ns/1ps
module bpm_ext_model
  import bpm_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic slow,
  input wire logic hreq,
  input wire logic [23:0] pat,
  // Pins from the mux
  input wire bpm_pkg::bpm_pin_type cs_pin,
  input wire bpm_pkg::bpm_pin_type stb_pin,
  input wire bpm_pkg::bpm_pin_type ctl_pin,
  // Levels at the pins
  output logic [7:0] cs_lvl,
  output logic [7:0] st_lvl,
  output logic [7:0] ct_lvl
);
  logic [1:0] wait_cnt_ff = 2'h0;
  logic [7:0] ext;
  always_ff @(posedge clk)
    if (slow && cs_pin.oe[0] && !cs_pin.out[0] && wait_cnt_ff == 2'h0) wait_cnt_ff <= 2'h2;
    else if (wait_cnt_ff != 2'h0) wait_cnt_ff <= wait_cnt_ff - 2'h1;
  always_comb begin
    ext = pat[23:16];
    ext[0] = (wait_cnt_ff == 2'h0);
    ext[3] = !hreq;
  end
  assign cs_lvl = (cs_pin.out & cs_pin.oe) | (pat[7:0] & ~cs_pin.oe);
  assign st_lvl = (stb_pin.out & stb_pin.oe) | (pat[15:8] & ~stb_pin.oe);
  assign ct_lvl = (ctl_pin.out & ctl_pin.oe) | (ext & ~ctl_pin.oe);
endmodule

// ===== verif/test_bpm_pin_mux.sv
// Purpose: Self-checking bench of the bus-control pin mux.
// Assumes: Read data checked from a queue one cycle after each read.
// Notes: Pins checked a few cycles after each change.
`timescale 1ns/1ps
module test_bpm_pin_mux;
  import bpm_pkg::*;
  logic clk, rst_b, slow, hreq;
  logic pend = 1'b0;
  bpm_reg_req_type req;
  bpm_ctl_out_type co;
  bpm_ctl_in_type ci;
  bpm_pin_type csp, stp, ctp;
  logic [7:0] rdata, cs_lvl, st_lvl, ct_lvl, e;
  logic [23:0] pat;
  logic [31:0] r;
  logic [7:0] expq [$];
  int num_errors = 0, checked = 0, cyc = 0, seed = 37;
  logic [31:0] adr_tab [9] = '{OFF_CS_DIR, OFF_CS_FUNC, OFF_CS_ALT, OFF_STB_DIR, OFF_STB_FUNC,
    OFF_STB_LANE, OFF_CTL_FUNC, OFF_CTL_DIR, 32'h00000000};
  logic [7:0] rst_tab [9] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hBF, 8'h00, 8'h3D, 8'hFF, 8'h00};
  bpm_pin_mux dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata), .ctl_out(co),
    .ctl_in(ci), .cs_pin_in(cs_lvl), .cs_pin(csp), .stb_pin_in(st_lvl), .stb_pin(stp),
    .ctl_pin_in(ct_lvl), .ctl_pin(ctp));
  bpm_ext_model ext (.clk(clk), .slow(slow), .hreq(hreq), .pat(pat), .cs_pin(csp),
    .stb_pin(stp), .ctl_pin(ctp), .cs_lvl(cs_lvl), .st_lvl(st_lvl), .ct_lvl(ct_lvl));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    req <= '{a, d, m, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] x);
    expq.push_back(x);
    @(posedge clk);
    req <= '{a, 8'h00, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic new_co(input logic sd);
    r = $random(seed);
    r[18] = sd;
    co <= r[28:0];
  endtask
  function automatic logic [7:0] cs_want(input logic [7:0] alt);
    logic [7:0] s;
    s = co.chip_select_n;
    if (alt[5]) s[5] = co.io_read_strobe;
    if (alt[2]) s[2] = co.io_store_strobe;
    return s;
  endfunction
  function automatic logic [7:0] st_want(input logic [7:0] ln);
    logic [7:0] s;
    for (int i = 0; i < 4; i++)
      s[i] = co.sdram_access ? co.lane_data_mask[i] :
        ln[i] ? co.lane_byte_enable[i] : co.lane_store_strobe[i];
    s[7:4] = {co.bus_cycle_start_status, 1'b0,
      co.sdram_access ? co.sdram_store_enable : co.store_strobe, co.read_strobe};
    return s;
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (pend) chk("rdata", rdata, expq.pop_front());
    pend <= req.rd;
    if (cyc == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    co = '0;
    slow = 1'b0;
    hreq = 1'b0;
    pat = 24'h5A3C96;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    foreach (adr_tab[i]) rd(adr_tab[i], rst_tab[i]);
    wr(OFF_CS_DIR, 8'h00, 8'h08);
    rd(OFF_CS_DIR, 8'hF7);
    wr(OFF_STB_DIR, 8'h00, 8'hFF);
    rd(OFF_STB_DIR, 8'h40);
    wr(OFF_CS_ALT, 8'hFF, 8'hFF);
    rd(OFF_CS_ALT, 8'h24);
    $display("test reset and access done");
    wr(OFF_CS_DIR, 8'h00, 8'hFF);
    wr(OFF_CS_FUNC, 8'h00, 8'hFF);
    wr(OFF_CS_DATA, 8'hA5, 8'hFF);
    settle;
    chk("cs out", csp.out, 8'hA5);
    chk("cs oe", csp.oe, 8'hFF);
    rd(OFF_CS_DATA, 8'hA5);
    wr(OFF_CS_DIR, 8'hF0, 8'hFF);
    rd(OFF_CS_DATA, {pat[7:4], 4'h5});
    wr(OFF_CS_DIR, 8'h00, 8'hFF);
    wr(OFF_CS_FUNC, 8'hFF, 8'hFF);
    for (int k = 0; k < 6; k++) begin
      wr(OFF_CS_ALT, k[0] ? 8'h24 : 8'h00, 8'hFF);
      new_co(k[1]);
      settle;
      chk("cs func", csp.out, cs_want(k[0] ? 8'h24 : 8'h00));
    end
    $display("test chip select done");
    for (int k = 0; k < 6; k++) begin
      wr(OFF_STB_LANE, k[0] ? 8'h0F : 8'h00, 8'hFF);
      new_co(k[1]);
      settle;
      chk("stb func", stp.out & stp.oe, st_want(k[0] ? 8'h0F : 8'h00));
    end
    wr(OFF_STB_FUNC, 8'h00, 8'hFF);
    wr(OFF_STB_DATA, 8'h5A, 8'hFF);
    settle;
    chk("stb port", stp.out & stp.oe, 8'h1A);
    $display("test strobe done");
    wr(OFF_CTL_DIR, 8'hEB, 8'hFF);
    hreq <= 1'b1;
    new_co(1'b0);
    settle;
    chk("ctl oe", ctp.oe, 8'h14);
    chk("ctl out", ctp.out & 8'h14, {3'h0, co.refresh_request, 1'b0, co.hold_acknowledge, 2'h0});
    chk("ctl in", {4'h0, ci}, {4'h0, 1'b1, 1'b0, pat[21], pat[21]});
    @(posedge clk);
    co.chip_select_n <= 8'hFE;
    slow <= 1'b1;
    e = 8'h00;
    repeat (6) begin
      @(posedge clk);
      #1;
      e = e | {7'h00, !ci.wait_b};
    end
    chk("wait", e, 8'h01);
    slow <= 1'b0;
    wr(OFF_CTL_FUNC, 8'h00, 8'hFF);
    wr(OFF_CTL_DATA, 8'hFF, 8'hFF);
    settle;
    chk("ctl port in", {4'h0, ci}, 8'h0F);
    chk("ctl port out", ctp.out & ctp.oe, 8'h14);
    rd(OFF_CTL_FUNC, 8'h00);
    $display("test bus control done");
    // Let the last read answer be checked before reset clears it
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFF_CS_DIR, 8'hFF);
    repeat (3) @(posedge clk);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
